/* File: timer8_wave_defs.vh */
// constants for the 8-bit timer waveform mode control block
`ifndef TIMER8_WAVE_DEFS_VH
`define TIMER8_WAVE_DEFS_VH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define CTRL_A_DATA_OFS 8'h44
`define CTRL_B_DATA_OFS 8'h45
`define IO_SPACE_DELTA 8'h20
`define CTRL_A_RESET 8'h00
`define CTRL_B_RESET 8'h00
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CHAN_A_MODE_HI 7
`define CHAN_A_MODE_LO 6
`define CHAN_B_MODE_HI 5
`define CHAN_B_MODE_LO 4
`define WAVE_LOW_HI 1
`define WAVE_LOW_LO 0
`define WAVE_BIT2_POS 3
`define CTRL_A_MASK 8'hF3
`define CTRL_B_MASK 8'h0F
// ----------------------------------------------------------------------
// counter values and modes
// ----------------------------------------------------------------------
`define CNT_MAX 8'hFF
`define CNT_BOTTOM 8'h00
`define WM_NORMAL 3'h0
`define WM_PC_FF 3'h1
`define WM_CTC 3'h2
`define WM_FAST_FF 3'h3
`define WM_PC_CMP 3'h5
`define WM_FAST_CMP 3'h7
`endif

/* File: wave_out_unit.v */
// one compare output channel: match actions and pin takeover
`timescale 1ns/10ps
module wave_out_unit
(
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // mode
    input wire [1:0] out_mode,
    input wire [2:0] wave_mode,
    input wire is_chan_a,
    // counter events
    input wire match,
    input wire at_top,
    input wire at_bottom,
    input wire counting_up,
    input wire cmp_is_top,
    // pin
    output reg out_level_r,
    output reg out_connect_r
);
`include "timer8_wave_defs.vh"
    wire fast = (wave_mode == `WM_FAST_FF) || (wave_mode == `WM_FAST_CMP);
    wire pc = (wave_mode == `WM_PC_FF) || (wave_mode == `WM_PC_CMP);
    wire pwm = fast || pc;
    // code 01 under pwm: toggle only for channel a with bit2 set
    wire tgl_ok = !pwm || (is_chan_a && wave_mode[2]);
    wire connect = out_mode[1] || (out_mode[0] && tgl_ok);
    // in pwm modes, matches with compare at top are dropped when the high bit is set
    wire skip = pwm && out_mode[1] && cmp_is_top;
    // fast pwm channel b acts at top as printed; channel a at bottom
    wire fast_b_top = fast && !is_chan_a;
    reg nxt;
    // action decode per mode
    always @*
    begin
        nxt = out_level_r;
        if (out_mode == 2'b01)
        begin
            if (match && tgl_ok)
                nxt = ~out_level_r;
        end
        else if (!pwm)
        begin
            if (match && out_mode[1])
                nxt = out_mode[0];
        end
        else if (fast)
        begin
            if (skip)
            begin
                if (fast_b_top ? at_top : at_bottom)
                    nxt = ~out_mode[0];
            end
            else if (at_bottom && out_mode[1])
                nxt = ~out_mode[0];
            else if (match && out_mode[1])
                nxt = out_mode[0];
        end
        else
        begin
            if (skip)
            begin
                // compare at top: the level must equal a down-count match
                if (at_top)
                    nxt = ~out_mode[0];
            end
            else if (match && out_mode[1])
                nxt = counting_up ? out_mode[0] : ~out_mode[0];
        end
    end
    // level and takeover flops
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_level_r <= 1'b0;
            out_connect_r <= 1'b0;
        end
        else
        begin
            out_level_r <= nxt;
            out_connect_r <= connect;
        end
    end
endmodule

/* File: timer8_waveform_mode_control.v */
// 8-bit timer control registers, counter sequence and compare outputs
`timescale 1ns/10ps
module timer8_waveform_mode_control
(
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // register port
    input wire [7:0] reg_addr,
    input wire reg_io_space,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata_r,
    // counter side
    input wire timer_tick,
    input wire [7:0] compare_value_a,
    input wire [7:0] compare_value_b,
    output reg [7:0] count_r,
    output reg overflow_flag_r,
    // port pins
    input wire dir_a,
    input wire dir_b,
    input wire port_a_level,
    input wire port_b_level,
    output reg compare_out_a_pin_r,
    output reg compare_out_a_pin_oe_r,
    output reg compare_out_b_pin_r,
    output reg compare_out_b_pin_oe_r
);
`include "timer8_wave_defs.vh"
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // io accesses sit 0x20 below the data-space offset
    function hit;
        input [7:0] addr;
        input io;
        input [7:0] ofs;
        begin
            hit = io ? (addr == ofs - `IO_SPACE_DELTA) : (addr == ofs);
        end
    endfunction
    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    reg [7:0] waveform_control_a_r;
    reg [7:0] waveform_control_b_r;
    wire sel_a = hit(reg_addr, reg_io_space, `CTRL_A_DATA_OFS);
    wire sel_b = hit(reg_addr, reg_io_space, `CTRL_B_DATA_OFS);
    // only the bits this block owns are stored; the rest read zero
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            waveform_control_a_r <= `CTRL_A_RESET;
            waveform_control_b_r <= `CTRL_B_RESET;
        end
        else if (reg_wr)
        begin
            if (sel_a)
                waveform_control_a_r <= reg_wdata & `CTRL_A_MASK;
            if (sel_b)
                waveform_control_b_r <= reg_wdata & `CTRL_B_MASK;
        end
    end
    // registered read data, zero for unmapped addresses
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata_r <= 8'h00;
        else if (sel_a)
            reg_rdata_r <= waveform_control_a_r;
        else if (sel_b)
            reg_rdata_r <= waveform_control_b_r;
        else
            reg_rdata_r <= 8'h00;
    end
    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    wire [1:0] chan_a_output_mode =
        waveform_control_a_r[`CHAN_A_MODE_HI:`CHAN_A_MODE_LO];
    wire [1:0] chan_b_output_mode =
        waveform_control_a_r[`CHAN_B_MODE_HI:`CHAN_B_MODE_LO];
    wire [1:0] wave_mode_low_bits =
        waveform_control_a_r[`WAVE_LOW_HI:`WAVE_LOW_LO];
    wire wave_mode_bit2 = waveform_control_b_r[`WAVE_BIT2_POS];
    wire [2:0] wave_mode = {wave_mode_bit2, wave_mode_low_bits};
    wire top_from_a = (wave_mode == `WM_CTC) || (wave_mode == `WM_PC_CMP)
        || (wave_mode == `WM_FAST_CMP);
    wire is_pc = (wave_mode == `WM_PC_FF) || (wave_mode == `WM_PC_CMP);
    wire is_fast = (wave_mode == `WM_FAST_FF) || (wave_mode == `WM_FAST_CMP);
    // ------------------------------------------------------------------
    // double-buffered compare values
    // ------------------------------------------------------------------
    reg [7:0] cmp_a_r;
    reg [7:0] cmp_b_r;
    reg up_r;
    // top follows the buffered value a, so a new period waits for update
    wire [7:0] top_val = top_from_a ? cmp_a_r : `CNT_MAX;
    wire at_top = (count_r == top_val);
    wire at_bottom = (count_r == `CNT_BOTTOM);
    wire pc_turn_top = is_pc && up_r && at_top;
    wire pc_turn_bot = is_pc && !up_r && at_bottom;
    // buffer load moment per mode; reserved modes act as normal mode
    wire buf_load = !(is_pc || is_fast) ? 1'b1
        : is_pc ? (timer_tick && pc_turn_top)
        : (timer_tick && at_top);
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmp_a_r <= 8'h00;
            cmp_b_r <= 8'h00;
        end
        else if (buf_load)
        begin
            cmp_a_r <= compare_value_a;
            cmp_b_r <= compare_value_b;
        end
    end
    // ------------------------------------------------------------------
    // counter, direction and overflow flag
    // ------------------------------------------------------------------
    reg [7:0] count_nxt;
    reg up_nxt;
    reg ovf_nxt;
    always @*
    begin
        count_nxt = count_r;
        up_nxt = up_r;
        ovf_nxt = 1'b0;
        if (timer_tick)
        begin
            if (is_pc)
            begin
                // dual slope, turns back on the tick that finds top, with no hold
                if (pc_turn_top)
                begin
                    up_nxt = 1'b0;
                    count_nxt = count_r - 8'h01;
                end
                else if (pc_turn_bot)
                begin
                    up_nxt = 1'b1;
                    count_nxt = count_r + 8'h01;
                    ovf_nxt = 1'b1;
                end
                else
                    count_nxt = up_r ? count_r + 8'h01 : count_r - 8'h01;
            end
            else
            begin
                up_nxt = 1'b1;
                count_nxt = at_top ? `CNT_BOTTOM : count_r + 8'h01;
                if (wave_mode == `WM_FAST_CMP)
                    ovf_nxt = at_top;
                else
                    ovf_nxt = (count_r == `CNT_MAX);
            end
        end
    end
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_r <= 8'h00;
            up_r <= 1'b1;
            overflow_flag_r <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            up_r <= up_nxt;
            overflow_flag_r <= ovf_nxt; // one-cycle overflow event
        end
    end
    // ------------------------------------------------------------------
    // compare output channels
    // ------------------------------------------------------------------
    wire lvl_a;
    wire con_a;
    wire lvl_b;
    wire con_b;
    wave_out_unit chan_a
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .out_mode(chan_a_output_mode),
        .wave_mode(wave_mode),
        .is_chan_a(1'b1),
        .match(timer_tick && count_r == cmp_a_r),
        .at_top(timer_tick && at_top),
        .at_bottom(timer_tick && at_bottom),
        .counting_up(up_r),
        .cmp_is_top(cmp_a_r == top_val),
        .out_level_r(lvl_a),
        .out_connect_r(con_a)
    );
    wave_out_unit chan_b
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .out_mode(chan_b_output_mode),
        .wave_mode(wave_mode),
        .is_chan_a(1'b0),
        .match(timer_tick && count_r == cmp_b_r),
        .at_top(timer_tick && at_top),
        .at_bottom(timer_tick && at_bottom),
        .counting_up(up_r),
        .cmp_is_top(cmp_b_r == top_val),
        .out_level_r(lvl_b),
        .out_connect_r(con_b)
    );
    // pin mux: compare output takes over, driven only as output
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            compare_out_a_pin_r <= 1'b0;
            compare_out_a_pin_oe_r <= 1'b0;
            compare_out_b_pin_r <= 1'b0;
            compare_out_b_pin_oe_r <= 1'b0;
        end
        else
        begin
            compare_out_a_pin_r <= con_a ? lvl_a : port_a_level;
            compare_out_a_pin_oe_r <= dir_a;
            compare_out_b_pin_r <= con_b ? lvl_b : port_b_level;
            compare_out_b_pin_oe_r <= dir_b;
        end
    end
endmodule

/* File: timer8_wave_assertions.sv */
// concurrent checks on the timer waveform mode control ports
`timescale 1ns/10ps
module timer8_wave_assertions
(
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // register port
    input wire [7:0] reg_addr,
    input wire reg_io_space,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata_r,
    // counter side
    input wire timer_tick,
    input wire [7:0] compare_value_a,
    input wire [7:0] count_r,
    input wire overflow_flag_r,
    // pin a
    input wire dir_a,
    input wire compare_out_a_pin_oe_r
);
    // shadow of both control registers so mode checks know the mode
    wire [7:0] eff_addr = reg_io_space ? reg_addr + 8'h20 : reg_addr;
    reg [7:0] a_r;
    reg [7:0] b_r;
    wire [2:0] mode = {b_r[3], a_r[1:0]};
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            a_r <= 8'h00;
            b_r <= 8'h00;
        end
        else if (reg_wr && eff_addr == 8'h44)
            a_r <= reg_wdata & 8'hF3;
        else if (reg_wr && eff_addr == 8'h45)
            b_r <= reg_wdata & 8'h0F;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    oe_dir_a: assert property (
        1'b1 |=> compare_out_a_pin_oe_r == $past(dir_a))
        else $error("pin a enable does not follow direction");
    count_step_a: assert property (
        mode == 3'h0 && timer_tick |=> count_r == $past(count_r) + 8'h01)
        else $error("normal mode count did not step by one");
    max_ovf_a: assert property (
        mode == 3'h0 && timer_tick && count_r == 8'hFF |-> ##[1:2] overflow_flag_r)
        else $error("no overflow at max in normal mode");
    ctc_wrap_a: assert property (
        mode == 3'h2 && timer_tick && count_r == compare_value_a
        |=> count_r == 8'h00) else $error("clear on match did not wrap");
    fast_wrap_a: assert property (
        mode == 3'h7 && timer_tick && count_r == compare_value_a
        |=> count_r == 8'h00) else $error("fast mode 7 did not wrap");
    pc_turn_a: assert property (
        mode == 3'h1 && timer_tick && count_r == 8'hFF |=> count_r == 8'hFE)
        else $error("phase correct did not turn at top");
    pc_ovf_a: assert property (
        mode == 3'h1 && overflow_flag_r |-> count_r <= 8'h01)
        else $error("phase correct overflow away from bottom");
    no_map_a: assert property (
        eff_addr != 8'h44 && eff_addr != 8'h45 |=> reg_rdata_r == 8'h00)
        else $error("unmapped read not zero");
    ctrl_a_read_a: assert property (
        !reg_wr && eff_addr == 8'h44 |=> reg_rdata_r == $past(a_r))
        else $error("control a read mismatch");
    ctrl_b_read_a: assert property (
        !reg_wr && eff_addr == 8'h45 |=> reg_rdata_r == $past(b_r))
        else $error("control b read mismatch");
    fast_ovf_a: assert property (
        mode == 3'h7 && timer_tick && count_r == compare_value_a
        |=> overflow_flag_r) else $error("fast mode 7 no overflow at top");
    // main scenarios reached
    cover property (mode == 3'h7 && timer_tick && count_r == compare_value_a);
    cover property (mode == 3'h1 && overflow_flag_r);
    cover property (reg_wr && reg_io_space && eff_addr == 8'h44);
    cover property (mode == 3'h5 && timer_tick && count_r == compare_value_a);
endmodule

/* File: testbench.sv */
// self-checking bench for the timer waveform mode control block
`timescale 1ns/10ps
module testbench;
    // design connections
    reg clk_sys, rst_n, reg_io_space, reg_wr, timer_tick;
    reg [7:0] reg_addr, reg_wdata, compare_value_a, compare_value_b;
    reg dir_a, dir_b, port_a_level, port_b_level;
    wire [7:0] reg_rdata_r, count_r;
    wire overflow_flag_r, compare_out_a_pin_r, compare_out_a_pin_oe_r;
    wire compare_out_b_pin_r, compare_out_b_pin_oe_r;
    wire [7:0] pins = {6'h00, compare_out_b_pin_r, compare_out_a_pin_r};
    wire [7:0] oes = {6'h00, compare_out_b_pin_oe_r, compare_out_a_pin_oe_r};
    integer failures, samples_checked;
    logic p;
    timer8_waveform_mode_control uut
    (
        .clk_sys, .rst_n, .reg_addr, .reg_io_space, .reg_wr, .reg_wdata,
        .reg_rdata_r, .timer_tick, .compare_value_a, .compare_value_b,
        .count_r, .overflow_flag_r, .dir_a, .dir_b, .port_a_level,
        .port_b_level, .compare_out_a_pin_r, .compare_out_a_pin_oe_r,
        .compare_out_b_pin_r, .compare_out_b_pin_oe_r
    );
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    end
    endtask
    // one write strobe; idle address 0x00 is unmapped
    task wr(input logic io, input logic [7:0] addr, input logic [7:0] data);
    begin
        @(posedge clk_sys);
        #1;
        reg_io_space = io;
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
    end
    endtask
    // read data is registered, so look one edge after the address
    task rd(input logic io, input logic [7:0] addr, input logic [7:0] exp);
    begin
        @(posedge clk_sys);
        #1;
        reg_io_space = io;
        reg_addr = addr;
        @(posedge clk_sys);
        #1;
        chk("read data", exp, reg_rdata_r);
        reg_addr = 8'h00;
    end
    endtask
    // tick until the count shows v, then idle while the pins catch up
    task run_to(input logic [7:0] v);
        integer n;
    begin
        n = 0;
        timer_tick = 1'b1;
        @(posedge clk_sys);
        #1;
        while (count_r !== v && n < 600)
        begin
            @(posedge clk_sys);
            #1;
            n = n + 1;
        end
        timer_tick = 1'b0;
        chk("count", v, count_r);
        repeat (3) @(posedge clk_sys);
        #1;
    end
    endtask
    task conclude;
    begin
        if (failures == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task regs_test;
    begin
        rd(1'b0, 8'h44, 8'h00);
        rd(1'b1, 8'h25, 8'h00);
        wr(1'b1, 8'h24, 8'hFF);
        rd(1'b0, 8'h44, 8'hF3);
        wr(1'b0, 8'h45, 8'hFF);
        rd(1'b1, 8'h25, 8'h0F);
        rd(1'b0, 8'h24, 8'h00);
        wr(1'b0, 8'h44, 8'h00);
        wr(1'b0, 8'h45, 8'h00);
    end
    endtask
    // codes 3, 2, 1 in normal mode: set, clear, toggle on one match each
    task match_codes;
        integer i;
    begin
        compare_value_a = 8'h05;
        compare_value_b = 8'h07;
        for (i = 3; i > 0; i = i - 1)
        begin
            wr(1'b0, 8'h44, {i[1:0], i[1:0], 4'h0});
            run_to(8'h10);
            chk("pins", (i != 2) ? 8'h03 : 8'h00, pins);
        end
        wr(1'b0, 8'h44, 8'h00);
        repeat (3) @(posedge clk_sys);
        #1;
        chk("pins", 8'h00, pins);
        dir_a = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("enables", 8'h02, oes);
        dir_a = 1'b1;
    end
    endtask
    task fast_pwm;
    begin
        compare_value_a = 8'h80;
        compare_value_b = 8'h80;
        wr(1'b0, 8'h44, 8'hB3);
        run_to(8'h10);
        chk("pins", 8'h01, pins);
        // a new compare must wait for top
        compare_value_a = 8'h20;
        run_to(8'h30);
        chk("pins", 8'h01, pins);
        run_to(8'hC0);
        chk("pins", 8'h02, pins);
    end
    endtask
    task phase_pwm;
    begin
        compare_value_a = 8'h40;
        compare_value_b = 8'h40;
        wr(1'b0, 8'h44, 8'hB1);
        run_to(8'hFF);
        run_to(8'h30);
        chk("pins", 8'h01, pins);
        run_to(8'h80);
        chk("pins", 8'h02, pins);
    end
    endtask
    task top_modes;
    begin
        compare_value_a = 8'h30;
        wr(1'b0, 8'h44, 8'h52);
        run_to(8'h10);
        run_to(8'h10);
        port_a_level = 1'b1;
        port_b_level = 1'b1;
        wr(1'b0, 8'h44, 8'h53);
        run_to(8'h10);
        chk("pins", 8'h03, pins);
        wr(1'b0, 8'h45, 8'h08);
        run_to(8'h10);
        p = compare_out_a_pin_r;
        run_to(8'h10);
        chk("pins", {6'h00, 1'b1, ~p}, pins);
    end
    endtask
    // mode 5, both compares at top, inverting: cleared at top, never set
    task top_hold;
    begin
        compare_value_a = 8'h60;
        compare_value_b = 8'h60;
        wr(1'b0, 8'h44, 8'hF1);
        run_to(8'h60);
        run_to(8'h50);
        chk("pins", 8'h00, pins);
    end
    endtask
    // ------------------------------------------------------------------
    // clock, reset, sequence and watchdog
    // ------------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial
    begin
        {rst_n, reg_io_space, reg_wr, timer_tick} = 4'h0;
        {reg_addr, reg_wdata, compare_value_a, compare_value_b} = 32'h0;
        {dir_a, dir_b, port_a_level, port_b_level} = 4'hC;
        failures = 0;
        samples_checked = 0;
        repeat (16) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        regs_test;
        match_codes;
        fast_pwm;
        phase_pwm;
        top_modes;
        top_hold;
        conclude;
    end
    // the sequence needs well under 6000 cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        failures = failures + 1;
        $display("wrong value watchdog expected done seen hang");
        conclude;
    end
endmodule
bind timer8_waveform_mode_control timer8_wave_assertions chk_i
(
    .clk_sys, .rst_n, .reg_addr, .reg_io_space, .reg_wr, .reg_wdata,
    .reg_rdata_r, .timer_tick, .compare_value_a, .count_r,
    .overflow_flag_r, .dir_a, .compare_out_a_pin_oe_r
);
